// ### cod_code_mem.sv
`timescale 1ns/1ps
module cod_code_mem (
  input  wire logic        mclk,
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic [7:0]  rd_addr,
  output logic      [23:0] code
);
  logic [7:0] mem [256];
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
  assign code = {mem[rd_addr], mem[8'(rd_addr + 8'h01)], mem[8'(rd_addr + 8'h02)]};
endmodule

// ### cod_decode.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Bank register operand picks R0-R7 by opcode low three bits in the active bank.
// - Direct operand is 8-bit; up to 0x7F is data memory, 0x80 up special area.
// - Indirect operand address 0x00-0xFF comes from R0 or R1 by opcode bit 0.
// - Page-local target replaces low 11 bits of next instruction address.
// - Relative offset is signed byte added to next instruction address.
// - Full-range target reaches any code address.
// - Writes to status word change flags like arithmetic updates.
// - Add at 0x24-0x2F, add with carry 0x34-0x3F, standard byte and cycle pattern.
// - Subtract with borrow at 0x94-0x9F, same pattern as add.
// - AND, OR, XOR groups; direct,A is 2/3; direct,immediate is 3/4.
// - Rotates 0x23, 0x33, 0x03, 0x13 are one byte, one cycle.
// - Swap 0xC4, clear 0xE4, complement 0xF4 are one byte, one cycle.
// - Moves into the working byte: register, direct, indirect, immediate timings.
// - Moves into bank register: 0xF8 1/2, 0xA8 2/4, 0x78 2/2.
// - Moves into direct byte: 0xF5, 0x88, 0x85, 0x86, 0x75 with listed timing.
// - Moves into indirect RAM: 0xF6 1/3, 0xA6 2/5, 0x76 2/3.
// - Opcode 0x90 loads data pointer from wide constant, 3 bytes, 3 cycles.
// - Code moves 0x93 and 0x83 are one byte, three cycles.
// - External reads 0xE0, 0xE2-0xE3 are one byte, 3 to 10 cycles.
// - External writes 0xF0, 0xF2-0xF3 are one byte, 4 to 11 cycles.
// - Push 0xC0 is 2/4, pop 0xD0 is 2/3.
// - Exchange 0xC8 1/2, 0xC5 2/3, 0xC6 1/3; nibble exchange 0xD6 1/3.
// - Push increments stack pointer first; pointer is 0x07 after reset.
// - Bank select field chooses bank base 0x00, 0x08, 0x10 or 0x18.
// - Pointer select bit 0 uses pointer 0, 1 uses pointer 1.
module cod_decode
  import cod_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire cod_fetch_t  fetch,
  input  wire logic [7:0]  program_status_word,
  input  wire logic        pointer_select_bit,
  input  wire logic        stack_pointer_load,
  input  wire logic [7:0]  stack_pointer_value,
  input  wire logic        pop_done,
  output cod_decode_t      decoded
);

  cod_state_t state;
  cod_state_t next_state;

  logic [7:0]  bank_base;
  logic [7:0]  op;
  logic [15:0] rel_ext;
  cod_op_t     alu_op;
  logic        push_now;

  // Fills operation, operand modes, byte length and cycle count of one form
  function automatic cod_decode_t set_form(input cod_decode_t d,
                                           input cod_op_t     kind,
                                           input cod_mode_t   s,
                                           input cod_mode_t   t,
                                           input logic [1:0]  len,
                                           input logic [3:0]  cyc);
    cod_decode_t r;
    r        = d;
    r.known  = 1'b1;
    r.op     = kind;
    r.src    = s;
    r.dst    = t;
    r.length = len;
    r.cycles = cyc;
    return r;
  endfunction

  // Operation of the groups that share the low-nibble operand layout
  function automatic cod_op_t group_op(input logic [3:0] hi);
    cod_op_t r;
    case (hi)
      4'h2:    r = COD_OP_ADD;
      4'h3:    r = COD_OP_ADD_CARRY;
      4'h4:    r = COD_OP_OR;
      4'h5:    r = COD_OP_AND;
      4'h6:    r = COD_OP_XOR;
      4'h9:    r = COD_OP_SUB_BORROW;
      4'he:    r = COD_OP_MOV;
      default: r = COD_OP_NONE;
    endcase
    return r;
  endfunction

  always_comb begin
    op                               = fetch.opcode;
    bank_base                        = {3'h0, program_status_word[COD_RS_POS +: 2], 3'h0};
    rel_ext                          = {{8{fetch.byte2[7]}}, fetch.byte2};
    alu_op                           = group_op(op[7:4]);
    push_now                         = fetch.valid && op == 8'hc0;
    next_state                       = state;
    next_state.dec                   = '0;
    next_state.dec.valid             = fetch.valid;
    next_state.dec.op                = COD_OP_NONE;
    next_state.dec.src               = COD_SRC_NONE;
    next_state.dec.dst               = COD_SRC_NONE;
    next_state.dec.reg_addr          = bank_base | {5'h00, op[2:0]};
    next_state.dec.ind_ptr_addr      = bank_base | {7'h00, op[0]};
    next_state.dec.direct_addr       = fetch.byte2;
    next_state.dec.direct_special    = fetch.byte2 >= COD_DIRECT_SPECIAL;
    next_state.dec.page_target       = {fetch.next_pc[15:COD_PAGE_BITS], op[7:5],
                                        fetch.byte2};
    next_state.dec.rel_target        = fetch.next_pc + rel_ext;
    next_state.dec.full_target       = {fetch.byte2, fetch.byte3};
    next_state.dec.data_pointer_sel  = pointer_select_bit;
    next_state.dec.stack_pointer     = state.stack_pointer;
    // Working-byte destination forms of the arithmetic, logic and move groups
    if (alu_op != COD_OP_NONE && op[3:2] != 2'b00 && op != 8'he4) begin
      if (op[3]) begin
        next_state.dec = set_form(next_state.dec, alu_op,
                                  COD_SRC_REG,
                                  COD_SRC_WORK,
                                  2'd1,
                                  4'd1);
      end else if (op[1:0] == 2'b00) begin
        next_state.dec = set_form(next_state.dec, alu_op,
                                  COD_SRC_IMM,
                                  COD_SRC_WORK,
                                  2'd2,
                                  4'd2);
      end else if (op[1:0] == 2'b01) begin
        next_state.dec = set_form(next_state.dec, alu_op,
                                  COD_SRC_DIR,
                                  COD_SRC_WORK,
                                  2'd2,
                                  4'd2);
      end else begin
        next_state.dec = set_form(next_state.dec, alu_op,
                                  COD_SRC_IND,
                                  COD_SRC_WORK,
                                  2'd1,
                                  4'd2);
      end
    end
    case (op)
      8'h42, 8'h52, 8'h62: begin
        next_state.dec = set_form(next_state.dec, alu_op,
                                  COD_SRC_WORK,
                                  COD_SRC_DIR,
                                  2'd2,
                                  4'd3);
      end
      8'h43, 8'h53, 8'h63: begin
        next_state.dec = set_form(next_state.dec, alu_op,
                                  COD_SRC_IMM,
                                  COD_SRC_DIR,
                                  2'd3,
                                  4'd4);
      end
      8'h03, 8'h13, 8'h23, 8'h33: begin
        next_state.dec = set_form(next_state.dec, COD_OP_ROT,
                                  COD_SRC_WORK,
                                  COD_SRC_WORK,
                                  2'd1,
                                  4'd1);
      end
      8'hc4, 8'he4, 8'hf4: begin
        next_state.dec = set_form(next_state.dec, COD_OP_ACCU,
                                  COD_SRC_WORK,
                                  COD_SRC_WORK,
                                  2'd1,
                                  4'd1);
      end
      8'h74: begin
        next_state.dec = set_form(next_state.dec, COD_OP_MOV,
                                  COD_SRC_IMM,
                                  COD_SRC_WORK,
                                  2'd2,
                                  4'd2);
      end
      8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h7f: begin
        next_state.dec = set_form(next_state.dec, COD_OP_MOV,
                                  COD_SRC_IMM,
                                  COD_SRC_REG,
                                  2'd2,
                                  4'd2);
      end
      8'ha8, 8'ha9, 8'haa, 8'hab, 8'hac, 8'had, 8'hae, 8'haf: begin
        next_state.dec = set_form(next_state.dec, COD_OP_MOV,
                                  COD_SRC_DIR,
                                  COD_SRC_REG,
                                  2'd2,
                                  4'd4);
      end
      8'hf8, 8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'hfd, 8'hfe, 8'hff: begin
        next_state.dec = set_form(next_state.dec, COD_OP_MOV,
                                  COD_SRC_WORK,
                                  COD_SRC_REG,
                                  2'd1,
                                  4'd2);
      end
      8'hf5: begin
        next_state.dec = set_form(next_state.dec, COD_OP_MOV,
                                  COD_SRC_WORK,
                                  COD_SRC_DIR,
                                  2'd2,
                                  4'd3);
      end
      8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'h8f: begin
        next_state.dec = set_form(next_state.dec, COD_OP_MOV,
                                  COD_SRC_REG,
                                  COD_SRC_DIR,
                                  2'd2,
                                  4'd3);
      end
      8'h85: begin
        next_state.dec = set_form(next_state.dec, COD_OP_MOV,
                                  COD_SRC_DIR,
                                  COD_SRC_DIR,
                                  2'd3,
                                  4'd4);
      end
      8'h86, 8'h87: begin
        next_state.dec = set_form(next_state.dec, COD_OP_MOV,
                                  COD_SRC_IND,
                                  COD_SRC_DIR,
                                  2'd2,
                                  4'd4);
      end
      8'h75: begin
        next_state.dec = set_form(next_state.dec, COD_OP_MOV,
                                  COD_SRC_IMM,
                                  COD_SRC_DIR,
                                  2'd3,
                                  4'd3);
      end
      8'hf6, 8'hf7: begin
        next_state.dec = set_form(next_state.dec, COD_OP_MOV,
                                  COD_SRC_WORK,
                                  COD_SRC_IND,
                                  2'd1,
                                  4'd3);
      end
      8'ha6, 8'ha7: begin
        next_state.dec = set_form(next_state.dec, COD_OP_MOV,
                                  COD_SRC_DIR,
                                  COD_SRC_IND,
                                  2'd2,
                                  4'd5);
      end
      8'h76, 8'h77: begin
        next_state.dec = set_form(next_state.dec, COD_OP_MOV,
                                  COD_SRC_IMM,
                                  COD_SRC_IND,
                                  2'd2,
                                  4'd3);
      end
      8'h90: begin
        next_state.dec = set_form(next_state.dec, COD_OP_POINTER_LOAD,
                                  COD_SRC_IMM,
                                  COD_SRC_NONE,
                                  2'd3,
                                  4'd3);
      end
      8'h93, 8'h83: begin
        next_state.dec = set_form(next_state.dec, COD_OP_CODE,
                                  COD_SRC_WORK,
                                  COD_SRC_WORK,
                                  2'd1,
                                  4'd3);
      end
      8'he0, 8'he2, 8'he3: begin
        next_state.dec = set_form(next_state.dec, COD_OP_EXT,
                                  COD_SRC_IND,
                                  COD_SRC_WORK,
                                  2'd1,
                                  4'd3);
        next_state.dec.variable_time = 1'b1;
      end
      8'hf0, 8'hf2, 8'hf3: begin
        next_state.dec = set_form(next_state.dec, COD_OP_EXT,
                                  COD_SRC_WORK,
                                  COD_SRC_IND,
                                  2'd1,
                                  4'd4);
        next_state.dec.variable_time = 1'b1;
      end
      8'hc0: begin
        next_state.dec = set_form(next_state.dec, COD_OP_STACK,
                                  COD_SRC_DIR,
                                  COD_SRC_NONE,
                                  2'd2,
                                  4'd4);
      end
      8'hd0: begin
        next_state.dec = set_form(next_state.dec, COD_OP_STACK,
                                  COD_SRC_NONE,
                                  COD_SRC_DIR,
                                  2'd2,
                                  4'd3);
      end
      8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hce, 8'hcf: begin
        next_state.dec = set_form(next_state.dec, COD_OP_EXCHANGE,
                                  COD_SRC_REG,
                                  COD_SRC_WORK,
                                  2'd1,
                                  4'd2);
      end
      8'hc5: begin
        next_state.dec = set_form(next_state.dec, COD_OP_EXCHANGE,
                                  COD_SRC_DIR,
                                  COD_SRC_WORK,
                                  2'd2,
                                  4'd3);
      end
      8'hc6, 8'hc7: begin
        next_state.dec = set_form(next_state.dec, COD_OP_EXCHANGE,
                                  COD_SRC_IND,
                                  COD_SRC_WORK,
                                  2'd1,
                                  4'd3);
      end
      8'hd6, 8'hd7: begin
        next_state.dec = set_form(next_state.dec, COD_OP_EXCHANGE,
                                  COD_SRC_IND,
                                  COD_SRC_WORK,
                                  2'd1,
                                  4'd3);
      end
      default: begin
      end
    endcase
    // A status word destination makes the flag logic take the written value
    next_state.dec.status_word_write = next_state.dec.known && fetch.valid &&
                                       next_state.dec.dst == COD_SRC_DIR &&
                                       fetch.byte2 == COD_STATUS_WORD_ADDR;
    // Increment before the push write, decrement once the pop has read
    if (stack_pointer_load) begin
      next_state.stack_pointer = stack_pointer_value;
    end else if (push_now) begin
      next_state.stack_pointer = state.stack_pointer + 8'h01;
    end else if (pop_done) begin
      next_state.stack_pointer = state.stack_pointer - 8'h01;
    end
    if (push_now) begin
      next_state.dec.stack_pointer = state.stack_pointer + 8'h01;
    end
    if (!fetch.valid) begin
      next_state.dec.known = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state               <= '0;
      state.stack_pointer <= COD_STACK_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign decoded = state.dec;

endmodule

// ### cod_decode_sva.sv
`timescale 1ns/1ps
module cod_decode_sva
  import cod_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire cod_fetch_t  fetch,
  input wire logic [7:0]  program_status_word,
  input wire logic        pointer_select_bit,
  input wire logic        stack_pointer_load,
  input wire logic [7:0]  stack_pointer_value,
  input wire logic        pop_done,
  input wire cod_decode_t decoded
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [7:0] op;
  logic       go;
  assign op = fetch.opcode;
  assign go = fetch.valid;
  AST_BANK_REG: assert property (go && op[7:3] == 5'h1d |=>
    decoded.reg_addr == {3'h0, $past(program_status_word[4:3]), $past(op[2:0])})
    else $error("bank register address wrong");
  AST_DIRECT: assert property (go && op == 8'he5 |=>
    decoded.direct_special == ($past(fetch.byte2) >= 8'h80)) else $error("direct area wrong");
  AST_INDIRECT: assert property (go && op[7:1] == 7'h73 |=>
    decoded.ind_ptr_addr == {3'h0, $past(program_status_word[4:3]), 2'h0, $past(op[0])})
    else $error("indirect pointer address wrong");
  AST_REL: assert property (go |=> decoded.rel_target ==
    $past(fetch.next_pc) + {{8{$past(fetch.byte2[7])}}, $past(fetch.byte2)})
    else $error("relative target wrong");
  AST_FULL: assert property (go |=>
    decoded.full_target == {$past(fetch.byte2), $past(fetch.byte3)}) else $error("full target wrong");
  AST_ONE_CYCLE: assert property (
    go && op inside {8'h03, 8'h13, 8'h23, 8'h33, 8'hc4, 8'he4, 8'hf4}
    |=> decoded.length == 2'h1 && decoded.cycles == 4'h1) else $error("single cycle op wrong");
  AST_EXT: assert property (
    go && op inside {8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3} |=> decoded.variable_time
    && decoded.cycles == ($past(op[4]) ? 4'h4 : 4'h3)) else $error("external move wrong");
  AST_PUSH_LOAD: assert property (stack_pointer_load ##1 (!go && !pop_done)
    ##1 (go && op == 8'hc0 && !stack_pointer_load && !pop_done)
    |=> decoded.stack_pointer == $past(stack_pointer_value, 3) + 8'h01) else $error("push wrong");
  AST_IDLE: assert property (!go |=> !decoded.valid && !decoded.known)
    else $error("idle fetch decoded");
  AST_PTR_SEL: assert property (go |=> decoded.data_pointer_sel == $past(pointer_select_bit))
    else $error("pointer select wrong");
  AST_STATUS_WORD: assert property (go && op == 8'hf5 && fetch.byte2 == 8'hd0 |=>
    decoded.status_word_write) else $error("status word write missed");
  cover property (go && op == 8'hc0);
  cover property (go && op == 8'he0);
  cover property (stack_pointer_load ##2 go);
endmodule
bind cod_decode cod_decode_sva u_sva (.mclk(mclk), .reset_n(reset_n), .fetch(fetch),
  .program_status_word(program_status_word), .pointer_select_bit(pointer_select_bit),
  .stack_pointer_load(stack_pointer_load), .stack_pointer_value(stack_pointer_value),
  .pop_done(pop_done), .decoded(decoded));

// ### cod_pkg.sv
package cod_pkg;

  localparam logic [7:0] COD_STACK_RESET  = 8'h07;
  localparam logic [7:0] COD_DIRECT_SPECIAL = 8'h80;
  localparam logic [7:0] COD_STATUS_WORD_ADDR = 8'hd0;
  localparam logic [1:0] COD_BANK_RESET   = 2'h0;
  localparam int         COD_RS_POS       = 3;
  localparam int         COD_BANK_SHIFT   = 3;
  localparam int         COD_PAGE_BITS    = 11;

  typedef enum logic [3:0] {
    COD_OP_NONE   = 4'b0000,
    COD_OP_ADD    = 4'b0001,
    COD_OP_ADD_CARRY  = 4'b0010,
    COD_OP_SUB_BORROW = 4'b0011,
    COD_OP_AND    = 4'b0100,
    COD_OP_OR     = 4'b0101,
    COD_OP_XOR    = 4'b0110,
    COD_OP_ROT    = 4'b0111,
    COD_OP_ACCU   = 4'b1000,
    COD_OP_MOV    = 4'b1001,
    COD_OP_CODE   = 4'b1010,
    COD_OP_EXT    = 4'b1011,
    COD_OP_STACK  = 4'b1100,
    COD_OP_EXCHANGE     = 4'b1101,
    COD_OP_POINTER_LOAD = 4'b1110
  } cod_op_t;

  typedef enum logic [2:0] {
    COD_SRC_NONE  = 3'b000,
    COD_SRC_REG   = 3'b001,
    COD_SRC_DIR   = 3'b010,
    COD_SRC_IND   = 3'b011,
    COD_SRC_IMM   = 3'b100,
    COD_SRC_WORK  = 3'b101
  } cod_mode_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  opcode;
    logic [7:0]  byte2;
    logic [7:0]  byte3;
    logic [15:0] next_pc;
  } cod_fetch_t;

  typedef struct packed {
    logic        valid;
    logic        known;
    cod_op_t     op;
    cod_mode_t   src;
    cod_mode_t   dst;
    logic [1:0]  length;
    logic [3:0]  cycles;
    logic        variable_time;
    logic [7:0]  reg_addr;
    logic [7:0]  ind_ptr_addr;
    logic [7:0]  direct_addr;
    logic        direct_special;
    logic [15:0] page_target;
    logic [15:0] rel_target;
    logic [15:0] full_target;
    logic        data_pointer_sel;
    logic        status_word_write;
    logic [7:0]  stack_pointer;
  } cod_decode_t;

  typedef struct packed {
    cod_decode_t dec;
    logic [7:0]  stack_pointer;
  } cod_state_t;

endpackage

// ### cpu_opcode_decode_datamove_tb_top.sv
`timescale 1ns/1ps
module cpu_opcode_decode_datamove_tb_top
  import cod_pkg::*;
;
  logic        mclk = 0, reset_n = 0, pointer_sel = 0, ld = 0, pd = 0, wr_en = 0;
  logic [7:0]  status_word = 0, stack_val = 0, wr_addr = 0, wr_data = 0, rd_addr = 0, op, b2;
  logic [23:0] code;
  logic [15:0] seed = 16'h8f8c, pc = 0, npc;
  logic [6:0]  e;
  cod_fetch_t  fetch = '0;
  cod_decode_t decoded;
  int          mismatches = 0, total_checks = 0, cycles = 0;
  cod_decode dut (.mclk(mclk), .reset_n(reset_n), .fetch(fetch),
    .program_status_word(status_word), .pointer_select_bit(pointer_sel),
    .stack_pointer_load(ld), .stack_pointer_value(stack_val),
    .pop_done(pd), .decoded(decoded));
  cod_code_mem mem (.mclk(mclk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .code(code));
  always #5 mclk = ~mclk;
  function logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function logic [6:0] pk(input logic [1:0] l, input logic [3:0] c);
    return {1'b1, l, c};
  endfunction
  function logic [6:0] exp_lc(input logic [7:0] o);
    case (o) inside
      8'h03, 8'h13, 8'h23, 8'h33, 8'hc4, 8'he4, 8'hf4: return pk(2'h1, 4'h1);
      8'h42, 8'h52, 8'h62, 8'hf5, 8'hc5, 8'hd0, [8'h88:8'h8f], [8'h76:8'h77]: return pk(2'h2, 4'h3);
      8'h43, 8'h53, 8'h63, 8'h85: return pk(2'h3, 4'h4);
      8'h75, 8'h90: return pk(2'h3, 4'h3);
      8'h74, [8'h78:8'h7f]: return pk(2'h2, 4'h2);
      [8'hf8:8'hff], [8'hc8:8'hcf]: return pk(2'h1, 4'h2);
      [8'ha8:8'haf], [8'h86:8'h87], 8'hc0: return pk(2'h2, 4'h4);
      [8'hf6:8'hf7], [8'hc6:8'hc7], [8'hd6:8'hd7], 8'h93, 8'h83, 8'he0, 8'he2, 8'he3:
        return pk(2'h1, 4'h3);
      [8'ha6:8'ha7]: return pk(2'h2, 4'h5);
      8'hf0, 8'hf2, 8'hf3: return pk(2'h1, 4'h4);
      default: begin
        if (o[3:0] < 4'h4 || !(o[7:4] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'he})) begin
          return 7'h00;
        end
        if (o[3:1] == 3'h2) begin
          return pk(2'h2, 4'h2);
        end
        return (o[3:1] == 3'h3) ? pk(2'h1, 4'h2) : pk(2'h1, 4'h1);
      end
    endcase
  endfunction
  task automatic chk(input string name, input logic [15:0] x, input logic [15:0] y);
    total_checks++;
    if (y !== x) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", name, x, y);
    end
  endtask
  task automatic step(input logic v, input logic [7:0] o, input logic [7:0] c2,
                      input logic [7:0] c3, input logic [15:0] p, input logic l, input logic q);
    @(posedge mclk);
    fetch <= '{valid: v, opcode: o, byte2: c2, byte3: c3, next_pc: p};
    ld <= l;
    pd <= q;
    status_word <= seed[7:0];
    pointer_sel <= seed[8];
    seed = lfsr(seed);
    @(posedge mclk);
    fetch.valid <= 1'b0;
    ld <= 1'b0;
    pd <= 1'b0;
    #1;
  endtask
  task automatic results;
    if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      results;
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    step(1, 8'hc0, 8'h10, 8'h00, 16'h0002, 0, 0);
    chk("push_first", 16'h08, 16'(decoded.stack_pointer));
    step(1, 8'hc0, 8'h11, 8'h00, 16'h0002, 0, 0);
    chk("push_second", 16'h09, 16'(decoded.stack_pointer));
    step(0, 8'h24, 8'h00, 8'h00, 16'h0000, 0, 1);
    chk("idle_known", 16'h0, 16'(decoded.known));
    step(1, 8'hc0, 8'h12, 8'h00, 16'h0002, 0, 0);
    chk("push_after_pop", 16'h09, 16'(decoded.stack_pointer));
    stack_val <= 8'hff;
    step(0, 8'h00, 8'h00, 8'h00, 16'h0000, 1, 0);
    step(1, 8'hc0, 8'h13, 8'h00, 16'h0002, 0, 0);
    chk("push_wrap", 16'h00, 16'(decoded.stack_pointer));
    @(posedge mclk);
    reset_n <= 1'b0;
    @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    chk("reset_clear", 16'h0, 16'(decoded.known));
    step(1, 8'hc0, 8'h14, 8'h00, 16'h0002, 0, 0);
    chk("push_after_reset", 16'h08, 16'(decoded.stack_pointer));
    step(1, 8'hf5, 8'hd0, 8'h00, 16'h0002, 0, 0);
    chk("status_word_write", 16'h1, 16'(decoded.status_word_write));
    step(1, 8'hf5, 8'hd1, 8'h00, 16'h0002, 0, 0);
    chk("status_word_skip", 16'h0, 16'(decoded.status_word_write));
    for (int k = 0; k < 2; k++) begin
      step(1, 8'he5, 8'(8'h7f + k), 8'h00, 16'h0002, 0, 0);
      chk("direct_area", 16'(k), 16'(decoded.direct_special));
    end
    for (int i = 0; i < 256; i++) begin
      @(posedge mclk);
      wr_en <= 1'b1;
      wr_addr <= 8'(i);
      wr_data <= seed[7:0];
      seed = lfsr(seed);
    end
    @(posedge mclk);
    wr_en <= 1'b0;
    for (int n = 0; n < 400; n++) begin
      rd_addr = pc[7:0];
      #1;
      op = (n < 256) ? 8'(n) : code[23:16];
      b2 = code[15:8];
      e = exp_lc(op);
      npc = {seed[15:8], 8'(pc[7:0] + ((e[5:4] == 2'h0) ? 2'h1 : e[5:4]))};
      step(1, op, b2, code[7:0], npc, 0, 0);
      chk("known", 16'(e[6]), 16'(decoded.known));
      chk("length", 16'(e[5:4]), 16'(decoded.length));
      chk("cycles", 16'(e[3:0]), 16'(decoded.cycles));
      chk("variable", 16'(op inside {8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3}),
          16'(decoded.variable_time));
      chk("page", {npc[15:11], op[7:5], b2}, decoded.page_target);
      chk("rel", npc + {{8{b2[7]}}, b2}, decoded.rel_target);
      chk("reg_addr", 16'({3'h0, status_word[4:3], op[2:0]}),
          16'(decoded.reg_addr));
      chk("ind_ptr", 16'({3'h0, status_word[4:3], 2'h0, op[0]}),
          16'(decoded.ind_ptr_addr));
      chk("direct", 16'(b2), 16'(decoded.direct_addr));
      chk("full", {b2, code[7:0]}, decoded.full_target);
      chk("pointer_sel", 16'(pointer_sel), 16'(decoded.data_pointer_sel));
      chk("valid", 16'h1, 16'(decoded.valid));
      pc = npc;
    end
    results;
  end
endmodule
